// [ics_clock_stretch.sv]
/*
 * Slave clock stretching and clock synchronisation for a serial
 * bus port. Tracks bit edges, clears the release bit on hardware
 * events and holds SCL low while stretching.
 * Assumes an open-drain SCL resolved outside, and a slave engine
 * on the same clock reporting address match and direction.
 */
`default_nettype none

module ics_clock_stretch (
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // Bus pins
    input  wire logic                   scl_in,
    input  wire logic                   sda_in,
    output logic                        scl_out,
    output logic                        scl_oe_n_out,
    // Configuration
    input  wire ics_pkg::ics_hold_cfg_t hold_cfg_in,
    input  wire logic                   master_mode_in,
    input  wire logic                   master_scl_release_in,
    // Software access
    input  wire ics_pkg::ics_ctrl_cmd_t ctrl_cmd_in,
    input  wire logic                   slave_address_reg_wr_in,
    input  wire logic                   address_update_flag_in,
    // Slave engine
    input  wire ics_pkg::ics_byte_info_t byte_info_in,
    // Status
    output logic                        scl_release_ctrl_out,
    output logic                        stretching_out,
    output logic                        master_wait_out
);

    // ------------------------------------------------------------
    // Pin synchronisation and edges
    // ------------------------------------------------------------
    ics_pkg::ics_pins_t pins_sync;
    logic               scl_d_r;
    logic               sda_d_r;
    logic               scl_fall;
    logic               start_det;
    logic               stop_det;

    ics_sync2 #(
        .WIDTH       (2)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .async_in    ({scl_in, sda_in}),
        .sync_out    (pins_sync)
    );

    assign scl_fall  = scl_d_r && !pins_sync.scl;
    assign start_det = pins_sync.scl && scl_d_r && sda_d_r
                       && !pins_sync.sda;
    assign stop_det  = pins_sync.scl && scl_d_r && !sda_d_r
                       && pins_sync.sda;

    // ------------------------------------------------------------
    // Byte tracking
    // ------------------------------------------------------------
    logic [3:0] edge_cnt_r;
    logic [3:0] edge_cnt_nxt;
    logic       active_r;
    logic       active_nxt;
    logic       first_byte_r;
    logic       first_byte_nxt;
    logic       matched_r;
    logic       matched_nxt;
    logic       read_xfer_r;
    logic       read_xfer_nxt;
    logic       scl_d_nxt;
    logic       sda_d_nxt;
    logic       edge8;
    logic       edge9;

    function automatic logic at_edge(input logic [3:0] cnt,
                                     input logic [3:0] num);
        at_edge = (cnt == num);
    endfunction : at_edge

    // Edge number that this falling edge completes
    assign edge8 = active_r && scl_fall
                   && at_edge(edge_cnt_r + 4'h1, ics_pkg::EDGE_DATA_END);
    assign edge9 = active_r && scl_fall
                   && at_edge(edge_cnt_r + 4'h1, ics_pkg::EDGE_ACK_END);

    always_comb
    begin
        scl_d_nxt      = pins_sync.scl;
        sda_d_nxt      = pins_sync.sda;
        edge_cnt_nxt   = edge_cnt_r;
        active_nxt     = active_r;
        first_byte_nxt = first_byte_r;
        matched_nxt    = matched_r;
        read_xfer_nxt  = read_xfer_r;
        if (start_det)
        begin
            edge_cnt_nxt   = ics_pkg::EDGE_CNT_PRE;
            active_nxt     = 1'b1;
            first_byte_nxt = 1'b1;
            matched_nxt    = 1'b0;
            read_xfer_nxt  = 1'b0;
        end
        else if (stop_det)
        begin
            active_nxt    = 1'b0;
            matched_nxt   = 1'b0;
            read_xfer_nxt = 1'b0;
        end
        else if (active_r && scl_fall)
        begin
            if (edge9)
            begin
                edge_cnt_nxt   = ics_pkg::EDGE_CNT_RST;
                first_byte_nxt = 1'b0;
                if (first_byte_r)
                begin
                    matched_nxt   = byte_info_in.addr_match;
                    read_xfer_nxt = byte_info_in.addr_match
                                    && byte_info_in.rw_read;
                end
            end
            else
            begin
                edge_cnt_nxt = edge_cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            scl_d_r      <= 1'b1;
            sda_d_r      <= 1'b1;
            edge_cnt_r   <= ics_pkg::EDGE_CNT_RST;
            active_r     <= 1'b0;
            first_byte_r <= 1'b0;
            matched_r    <= 1'b0;
            read_xfer_r  <= 1'b0;
        end
        else
        begin
            scl_d_r      <= scl_d_nxt;
            sda_d_r      <= sda_d_nxt;
            edge_cnt_r   <= edge_cnt_nxt;
            active_r     <= active_nxt;
            first_byte_r <= first_byte_nxt;
            matched_r    <= matched_nxt;
            read_xfer_r  <= read_xfer_nxt;
        end
    end

    // ------------------------------------------------------------
    // Release bit and SCL hold
    // ------------------------------------------------------------
    logic ctrl_r;
    logic ctrl_nxt;
    logic hold_r;
    logic hold_nxt;
    logic upd_hold_r;
    logic upd_hold_nxt;
    logic mwait_r;
    logic mwait_nxt;
    logic addr_now;
    logic read_ack;
    logic hw_clr;
    logic upd_evt;

    // Address byte decisions use the live match from the engine
    assign addr_now = first_byte_r && byte_info_in.addr_match;
    // Buffer state is deliberately not an input here
    assign read_ack = edge9 && (first_byte_r ? byte_info_in.rw_read
                                && byte_info_in.addr_match
                                : read_xfer_r);
    assign hw_clr   = !master_mode_in && (read_ack
        || (edge9 && hold_cfg_in.stretch_after_ack_en
            && (addr_now || matched_r))
        || (edge8 && addr_now && hold_cfg_in.address_hold_en)
        || (edge8 && !first_byte_r && matched_r
            && hold_cfg_in.data_hold_en));
    assign upd_evt  = !master_mode_in && edge9
                      && address_update_flag_in;

    always_comb
    begin
        ctrl_nxt     = ctrl_r;
        upd_hold_nxt = upd_hold_r;
        hold_nxt     = hold_r;
        // Hardware clear wins over a same-cycle set, so no stretch
        // request is lost
        if (hw_clr)
        begin
            ctrl_nxt = 1'b0;
        end
        else if (ctrl_cmd_in.set)
        begin
            ctrl_nxt = 1'b1;
        end
        else if (ctrl_cmd_in.clr)
        begin
            ctrl_nxt = 1'b0;
        end
        // Update stretch leaves the release bit alone
        if (upd_evt)
        begin
            upd_hold_nxt = 1'b1;
        end
        else if (slave_address_reg_wr_in || master_mode_in)
        begin
            upd_hold_nxt = 1'b0;
        end
        if (master_mode_in)
        begin
            hold_nxt = 1'b0;
        end
        else if (!hold_r)
        begin
            // Only grab a line already seen low
            hold_nxt = (!ctrl_r || upd_hold_r) && !pins_sync.scl;
        end
        else
        begin
            // Let go; wired-AND keeps low while others hold
            hold_nxt = !ctrl_r || upd_hold_nxt;
        end
        // Generator waits on a slave holding the line
        mwait_nxt = master_mode_in && master_scl_release_in
                    && !pins_sync.scl;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_r     <= ics_pkg::CTRL_RST;
            upd_hold_r <= 1'b0;
            hold_r     <= ics_pkg::HOLD_RST;
            mwait_r    <= 1'b0;
        end
        else
        begin
            ctrl_r     <= ctrl_nxt;
            upd_hold_r <= upd_hold_nxt;
            hold_r     <= hold_nxt;
            mwait_r    <= mwait_nxt;
        end
    end

    assign scl_out              = 1'b0;
    assign scl_oe_n_out         = !hold_r;
    assign scl_release_ctrl_out = ctrl_r;
    assign stretching_out       = hold_r;
    assign master_wait_out      = mwait_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_no_self_low: assert property (
        $rose(hold_r) |-> $past(!pins_sync.scl))
        else $error("SCL hold began while line was high");
    a_hold_when_clr: assert property (
        (!ctrl_r && !hold_r && !pins_sync.scl && !master_mode_in)
        |=> hold_r)
        else $error("Cleared release bit did not hold low SCL");
    a_set_releases: assert property (
        (hold_r && ctrl_r && !upd_hold_r && !master_mode_in
         && !upd_evt) |=> !hold_r)
        else $error("Set release bit did not free SCL");
    a_hold_stays: assert property (
        (hold_r && !ctrl_r && !master_mode_in) |=> hold_r)
        else $error("SCL released before release bit set");
    a_read_ack_clr: assert property (
        (read_ack && !master_mode_in) |=> !ctrl_r ##1 hold_r)
        else $error("Read acknowledge did not stretch");
    a_stretch_en_clr: assert property (
        (edge9 && hold_cfg_in.stretch_after_ack_en && matched_r
         && !master_mode_in) |=> !ctrl_r)
        else $error("Stretch enable did not clear release bit");
    a_upd_keeps_ctrl: assert property (
        (upd_evt && !hw_clr && !ctrl_cmd_in.clr && ctrl_r)
        |=> ctrl_r ##1 hold_r)
        else $error("Address update changed release bit");
    a_upd_release: assert property (
        (hold_r && upd_hold_r && ctrl_r && slave_address_reg_wr_in
         && !upd_evt && !master_mode_in) |=> !hold_r)
        else $error("Address write did not free SCL");
    a_addr_hold: assert property (
        (edge8 && addr_now && hold_cfg_in.address_hold_en
         && !master_mode_in) |=> !ctrl_r)
        else $error("Address hold did not clear release bit");
    a_data_hold: assert property (
        (edge8 && !first_byte_r && matched_r
         && hold_cfg_in.data_hold_en && !master_mode_in) |=> !ctrl_r)
        else $error("Data hold did not clear release bit");
    a_master_free: assert property (
        $past(master_mode_in) |-> scl_oe_n_out)
        else $error("Slave stretch driven in master mode");

    c_read_stretch: cover property (read_ack ##[1:4] hold_r);
    c_upd_release: cover property (
        upd_hold_r && hold_r ##1 slave_address_reg_wr_in ##1 !hold_r);
    c_data_hold: cover property (
        edge8 && !first_byte_r && hold_cfg_in.data_hold_en);
    c_master_wait: cover property (master_wait_out);

endmodule : ics_clock_stretch

`default_nettype wire

// [ics_pkg.sv]
/*
 * Constants and carrier types for the slave clock-stretch block.
 * Assumes a single core clock domain; the serial bus pins are
 * synchronised before use by the block itself.
 */
// Contract
// - Release bit clear: wait SCL low, hold
// - Software sets release bit: stop holding SCL
// - Read request acknowledged: hardware clears release bit
// - Stretch enable: stretch after every acknowledge; the code does so only for a matched address or transfer
// - Buffer full never affects stretching
// - Read requests always clear and stretch
// - Address update: stretch, release bit untouched
// - Address register write ends update stretch
// - Address hold: clear after eighth edge
// - Data hold: clear after eighth edge
// - Never start a low phase itself
// - Hold until bit set, others released
// - Master mode: stretching hidden from software; the code reports a slave holding SCL on master_wait_out
`default_nettype none

package ics_pkg;

    // ------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------
    localparam int unsigned SYNC_STAGES  = 2;
    localparam logic [3:0]  EDGE_DATA_END = 4'h8;
    localparam logic [3:0]  EDGE_ACK_END  = 4'h9;
    localparam logic [3:0]  EDGE_CNT_RST  = 4'h0;
    // START's own SCL fall wraps the count to zero
    localparam logic [3:0]  EDGE_CNT_PRE  = 4'hf;
    localparam logic        CTRL_RST      = 1'b1;
    localparam logic        HOLD_RST      = 1'b0;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic stretch_after_ack_en;
        logic address_hold_en;
        logic data_hold_en;
    } ics_hold_cfg_t;

    typedef struct packed {
        logic set;
        logic clr;
    } ics_ctrl_cmd_t;

    typedef struct packed {
        logic addr_match;
        logic rw_read;
    } ics_byte_info_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } ics_pins_t;

endpackage : ics_pkg

`default_nettype wire

// [ics_sync2.sv]
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs are slow levels; no pulse is shorter than
 * two core clocks.
 */
`default_nettype none

module ics_sync2 #(
    parameter int unsigned WIDTH = 2
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // Idle bus reads high, so reset to ones
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_r <= '1;
            sync_r <= '1;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule : ics_sync2

`default_nettype wire

// [ics_master_model.sv]
/*
 * Behavioural serial bus master: START, bit pulses, STOP.
 * Assumes the bench resolves SCL as a wired-AND with the slave
 * and that SDA has a pull-up.
 */
`default_nettype none

module ics_master_model (
    // Resolved bus
    input  wire logic scl_bus_in,
    // Open-drain drive, 1 = released
    output logic      scl_drv_out,
    output logic      sda_drv_out
);
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF_NS = 80;

    initial
    begin
        scl_drv_out = 1'b1;
        sda_drv_out = 1'b1;
    end

    // Bounded so a stuck slave cannot hang the model for ever
    task automatic wait_high();
        int n;
        n = 0;
        while (scl_bus_in !== 1'b1 && n < 4000)
        begin
            #4;
            n++;
        end
    endtask : wait_high

    task automatic start_cond();
        sda_drv_out = 1'b0;
        #HALF_NS;
        scl_drv_out = 1'b0;
    endtask : start_cond

    task automatic pulses(input int cnt, input logic [8:0] bits);
        for (int i = cnt - 1; i >= 0; i--)
        begin
            sda_drv_out = bits[i];
            #HALF_NS;
            scl_drv_out = 1'b1;
            wait_high();
            #HALF_NS;
            scl_drv_out = 1'b0;
        end
    endtask : pulses

    task automatic stop_cond();
        sda_drv_out = 1'b0;
        #HALF_NS;
        scl_drv_out = 1'b1;
        wait_high();
        #HALF_NS;
        sda_drv_out = 1'b1;
        #HALF_NS;
    endtask : stop_cond

endmodule : ics_master_model

`default_nettype wire

// [testbench.sv]
/*
 * Self-checking bench for the slave clock-stretch block.
 * Assumes the master model and the block share SCL by wired-AND.
 */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct packed {
        ics_pkg::ics_hold_cfg_t cfg;
        logic                   match;
        logic                   rd;
        logic                   upd;
        logic                   e8;
        logic                   e9;
        logic                   es9;
    } ics_row_t;

    logic                    core_clk_in = 1'b0;
    logic                    rst_n_in = 1'b0;
    ics_pkg::ics_hold_cfg_t  cfg = '0;
    logic                    mst = 1'b0;
    logic                    mrel = 1'b0;
    ics_pkg::ics_ctrl_cmd_t  cmd = '0;
    logic                    adr_wr = 1'b0;
    logic                    upd = 1'b0;
    ics_pkg::ics_byte_info_t info = '0;
    logic                    scl_out;
    logic                    oe_n;
    logic                    rel;
    logic                    str;
    logic                    mwait;
    logic                    m_scl;
    logic                    m_sda;
    wire logic               scl_bus;
    int                      err_total = 0;
    int                      total_checks = 0;
    int                      cyc = 0;
    // cfg {stretch, addr hold, data hold}, match, rd, upd, e8, e9, es9
    ics_row_t rows [0:5] = '{
        '{3'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
        '{3'h2, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0},
        '{3'h2, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0},
        '{3'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1},
        '{3'h4, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1},
        '{3'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1}};

    assign scl_bus = m_scl & (oe_n | scl_out);

    always #2 core_clk_in = ~core_clk_in;

    ics_clock_stretch ics_clock_stretch_inst (
        .core_clk_in             (core_clk_in),
        .rst_n_in                (rst_n_in),
        .scl_in                  (scl_bus),
        .sda_in                  (m_sda),
        .scl_out                 (scl_out),
        .scl_oe_n_out            (oe_n),
        .hold_cfg_in             (cfg),
        .master_mode_in          (mst),
        .master_scl_release_in   (mrel),
        .ctrl_cmd_in             (cmd),
        .slave_address_reg_wr_in (adr_wr),
        .address_update_flag_in  (upd),
        .byte_info_in            (info),
        .scl_release_ctrl_out    (rel),
        .stretching_out          (str),
        .master_wait_out         (mwait)
    );

    ics_master_model ics_master_model_inst (
        .scl_bus_in  (scl_bus),
        .scl_drv_out (m_scl),
        .sda_drv_out (m_sda)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("Checks made %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : settle

    task automatic sw(input ics_pkg::ics_ctrl_cmd_t c, input logic w);
        @(posedge core_clk_in);
        cmd <= c;
        adr_wr <= w;
        @(posedge core_clk_in);
        cmd <= '0;
        adr_wr <= 1'b0;
    endtask : sw

    task automatic step(input logic [7:0] b, input logic e8, e9, es9);
        ics_master_model_inst.pulses(8, {1'h0, b});
        settle(30);
        chk("release_after_8", e8, rel);
        chk("scl_oe_n_after_8", e8, oe_n);
        if (rel !== 1'b1)
            sw(2'h2, 1'h0);
        ics_master_model_inst.pulses(1, 9'h1ff);
        settle(30);
        chk("release_after_9", e9, rel);
        chk("stretch_after_9", es9, str);
    endtask : step

    // Master still holds SCL low here, so release must not wait on it
    task automatic free();
        if (upd)
            sw(2'h0, 1'h1);
        else
            sw(2'h2, 1'h0);
        settle(3);
        chk("scl_oe_n_freed", 1'h1, oe_n);
        chk("stretch_freed", 1'h0, str);
        upd <= 1'b0;
    endtask : free

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end

    initial
    begin
        repeat (20) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        settle(2);
        chk("release_reset", 1'h1, rel);
        chk("scl_oe_n_reset", 1'h1, oe_n);
        chk("scl_out_level", 1'h0, scl_out);
        foreach (rows[k])
        begin
            @(posedge core_clk_in);
            cfg <= rows[k].cfg;
            info <= {rows[k].match, rows[k].rd};
            upd <= rows[k].upd;
            settle(2);
            ics_master_model_inst.start_cond();
            step({7'h2a, rows[k].rd}, rows[k].e8, rows[k].e9, rows[k].es9);
            free();
            ics_master_model_inst.stop_cond();
        end
        // Data hold acts on the data byte only
        @(posedge core_clk_in);
        cfg <= 3'h1;
        info <= 2'h2;
        ics_master_model_inst.start_cond();
        step(8'h54, 1'h1, 1'h1, 1'h0);
        step(8'ha5, 1'h0, 1'h1, 1'h0);
        free();
        ics_master_model_inst.stop_cond();
        // Clearing the bit on an idle bus must not pull SCL
        sw(2'h1, 1'h0);
        settle(20);
        chk("release_idle_clr", 1'h0, rel);
        chk("scl_oe_n_idle_clr", 1'h1, oe_n);
        sw(2'h2, 1'h0);
        // Reset in the middle of a read stretch
        @(posedge core_clk_in);
        cfg <= 3'h0;
        info <= 2'h3;
        ics_master_model_inst.start_cond();
        step(8'h55, 1'h1, 1'h0, 1'h1);
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        settle(3);
        chk("scl_oe_n_mid_reset", 1'h1, oe_n);
        chk("release_mid_reset", 1'h1, rel);
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        ics_master_model_inst.stop_cond();
        // Master mode: no slave stretch, wait is reported
        @(posedge core_clk_in);
        mst <= 1'b1;
        mrel <= 1'b1;
        // Cleared bit would grab SCL if master mode did not block it
        sw(2'h1, 1'h0);
        ics_master_model_inst.start_cond();
        ics_master_model_inst.pulses(9, 9'h0ab);
        settle(30);
        chk("scl_oe_n_master", 1'h1, oe_n);
        chk("master_wait", 1'h1, mwait);
        ics_master_model_inst.stop_cond();
        settle(2);
        chk("master_wait_idle", 1'h0, mwait);
        results();
    end

endmodule : testbench

`default_nettype wire
